// [core/csf_pkg.sv]
package csf_pkg;

  // ----------------------------------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CSF_ADDR_SPREG = 8'h00;
  localparam logic [7:0] CSF_ADDR_CTRL = 8'h04;
  localparam logic [7:0] CSF_ADDR_TOS = 8'h08;
  localparam logic [7:0] CSF_ADDR_SHADOW = 8'h0c;
  localparam logic [7:0] CSF_ADDR_PC = 8'h10;
  localparam logic [7:0] CSF_ADDR_INSTR = 8'h14;

  // ----------------------------------------------------------------
  // field positions and sizes
  // ----------------------------------------------------------------
  localparam int CSF_FULL_BIT = 7;
  localparam int CSF_UNF_BIT = 6;
  localparam int CSF_SP_W = 5;
  localparam int CSF_PC_W = 21;
  localparam int CSF_DEPTH = 31;
  localparam int CSF_CTRL_RSTEN_BIT = 0;
  localparam logic [4:0] CSF_SP_RESET = 5'h00;
  localparam logic [4:0] CSF_SP_MAX = 5'h1f;
  localparam logic [20:0] CSF_PC_RESET = 21'h00000;
  localparam logic [20:0] CSF_PC_STEP = 21'h00002;
  localparam logic CSF_RSTEN_RESET = 1'b1;

  // ----------------------------------------------------------------
  // instruction-cycle phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSF_Q1 = 4'b0001,
    CSF_Q2 = 4'b0010,
    CSF_Q3 = 4'b0100,
    CSF_Q4 = 4'b1000
  } csf_phase_t;

  // ----------------------------------------------------------------
  // flow command from the executing instruction
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSF_OP_NONE = 3'h0,
    CSF_OP_CALL = 3'h1,
    CSF_OP_RET = 3'h2,
    CSF_OP_GOTO = 3'h3,
    CSF_OP_BRANCH = 3'h4,
    CSF_OP_RETINT = 3'h5,
    CSF_OP_INT = 3'h6,
    CSF_OP_PCADD = 3'h7
  } csf_op_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [3:0] bank;
  } csf_ctx_t;

  typedef struct packed {
    csf_op_t op;
    logic fast;
    logic [19:0] target;
    logic [10:0] offset;
    logic [7:0] pc_add;
  } csf_cmd_t;

endpackage : csf_pkg

// [core/csf_core.sv]
// Operation
// - eight-bit pointer register, full, underflow, zero bit
// - five-bit pointer field, read/write, resets zero
// - full flag set when stack fills
// - underflow on empty pop; flags sticky
// - error reset enabled: flag and device reset on the same edge
// - error reset disabled: flag only
// - one-deep hidden shadow of status, w, bank
// - every interrupt vectoring saves shadow
// - fast interrupt return restores shadow
// - nested interrupt overwrites single shadow level
// - fast call saves, fast return restores
// - core clock divided into four phases
// - pc increments phase one, instruction loads phase four
// - operand read phase two, write phase four
// - fetch overlaps; pc change flushes fetched word
// - pc steps by two, bit zero reads zero
// - absolute targets load pc bits 20:1
// - branch offsets count words, not bytes
// - table reads byte address, one byte each
// - push increments then writes; pop reads then decrements
// - 31 entries of 21 bits; zero unbacked
// - empty pop returns zero, pointer stays zero
// - no overwrite or advance beyond 31
`timescale 1ns/1ns
`default_nettype none
module csf_core #(
  parameter int DEPTH = csf_pkg::CSF_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // program memory fetch
  output logic [20:0] PM_ADDR,
  output logic PM_REQ,
  input wire logic [15:0] PM_WORD,
  input wire logic [7:0] PM_BYTE,
  // table read
  input wire logic TBL_REQ,
  input wire logic [20:0] TBL_PTR,
  output logic [7:0] TBL_LATCH,
  // execution side
  input wire csf_pkg::csf_cmd_t CMD,
  input wire csf_pkg::csf_ctx_t CTX,
  output csf_pkg::csf_ctx_t CTX_RESTORE,
  output logic CTX_LOAD,
  output logic [15:0] INSTR_WORD,
  output logic FLUSH,
  output logic [3:0] PHASE,
  output logic DM_RD,
  output logic DM_WR,
  output logic DEV_RESET
);
  import csf_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // phase generator
  // ----------------------------------------------------------------
  csf_phase_t phase_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= CSF_Q1;
    end else begin
      unique case (phase_q)
        CSF_Q1: phase_q <= CSF_Q2;
        CSF_Q2: phase_q <= CSF_Q3;
        CSF_Q3: phase_q <= CSF_Q4;
        CSF_Q4: phase_q <= CSF_Q1;
        default: phase_q <= CSF_Q1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_wr;
  logic apb_rd;
  logic sp_wr;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign sp_wr = apb_wr && (PADDR == CSF_ADDR_SPREG);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic rsten_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rsten_q <= CSF_RSTEN_RESET;
    end else if (apb_wr && PADDR == CSF_ADDR_CTRL) begin
      rsten_q <= PWDATA[CSF_CTRL_RSTEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // flow decode, acted on at the end of q4
  // ----------------------------------------------------------------
  logic exec_now;
  logic do_push;
  logic do_pop;
  logic do_save;
  logic do_restore;
  logic is_int;
  assign exec_now = (phase_q == CSF_Q4);
  assign is_int = (CMD.op == CSF_OP_INT);
  assign do_push = exec_now && (CMD.op == CSF_OP_CALL || is_int);
  assign do_pop = exec_now && (CMD.op == CSF_OP_RET || CMD.op == CSF_OP_RETINT);
  assign do_save = exec_now && (is_int || (CMD.op == CSF_OP_CALL && CMD.fast));
  assign do_restore = do_pop && CMD.fast;

  // ----------------------------------------------------------------
  // return stack pointer and flags
  // ----------------------------------------------------------------
  logic [4:0] sp_q;
  logic full_q;
  logic unf_q;
  logic [20:0] stack_q [1:DEPTH];
  logic push_ok;
  logic push_fills;
  logic pop_empty;
  logic stack_err;
  logic [20:0] tos;
  logic [20:0] pc_q;
  assign push_ok = do_push && (sp_q < 5'(DEPTH));
  assign push_fills = do_push && (sp_q >= 5'(DEPTH - 1));
  assign pop_empty = do_pop && (sp_q == CSF_SP_RESET);
  assign stack_err = rsten_q && (push_fills || pop_empty);
  assign tos = (sp_q == CSF_SP_RESET) ? CSF_PC_RESET : stack_q[sp_q];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= CSF_SP_RESET;
    end else if (sp_wr) begin
      sp_q <= PWDATA[CSF_SP_W-1:0];
    end else if (stack_err) begin
      sp_q <= CSF_SP_RESET;
    end else if (push_ok) begin
      sp_q <= sp_q + 5'h01;
    end else if (do_pop && !pop_empty) begin
      sp_q <= sp_q - 5'h01;
    end
  end

  // flags survive the stack error reset; set wins over software clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      if (push_fills) begin
        full_q <= 1'b1;
      end else if (sp_wr && !PWDATA[CSF_FULL_BIT]) begin
        full_q <= 1'b0;
      end
      if (pop_empty) begin
        unf_q <= 1'b1;
      end else if (sp_wr && !PWDATA[CSF_UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi <= DEPTH; gi++) begin : g_stack
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          stack_q[gi] <= CSF_PC_RESET;
        end else if (push_ok && !stack_err && sp_q == 5'(gi - 1)) begin
          stack_q[gi] <= pc_q;
        end else if (apb_wr && PADDR == CSF_ADDR_TOS && sp_q == 5'(gi)) begin
          stack_q[gi] <= PWDATA[CSF_PC_W-1:0] & ~CSF_PC_RESET;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DEV_RESET <= 1'b0;
    end else begin
      DEV_RESET <= stack_err;
    end
  end

  // ----------------------------------------------------------------
  // shadow register stack
  // ----------------------------------------------------------------
  csf_ctx_t shadow_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      shadow_q <= '0;
    end else if (do_save) begin
      shadow_q <= CTX;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CTX_RESTORE <= '0;
      CTX_LOAD <= 1'b0;
    end else begin
      CTX_RESTORE <= shadow_q;
      CTX_LOAD <= do_restore;
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  logic [20:0] pc_d;
  logic pc_jump;
  logic [20:0] br_bytes;
  assign br_bytes = {{9{CMD.offset[10]}}, CMD.offset, 1'b0};
  always_comb begin
    pc_jump = 1'b0;
    pc_d = pc_q;
    if (phase_q == CSF_Q1) begin
      pc_d = pc_q + CSF_PC_STEP;
    end else if (exec_now && !stack_err) begin
      unique case (CMD.op)
        CSF_OP_CALL, CSF_OP_GOTO: begin
          pc_d = {CMD.target, 1'b0};
          pc_jump = 1'b1;
        end
        CSF_OP_BRANCH: begin
          pc_d = pc_q + br_bytes;
          pc_jump = 1'b1;
        end
        CSF_OP_RET, CSF_OP_RETINT: begin
          pc_d = tos;
          pc_jump = 1'b1;
        end
        CSF_OP_INT: begin
          pc_d = {CMD.target, 1'b0};
          pc_jump = 1'b1;
        end
        CSF_OP_PCADD: begin
          pc_d = {pc_q[20:8], pc_q[7:0] + CMD.pc_add};
          pc_jump = 1'b1;
        end
        CSF_OP_NONE: pc_d = pc_q;
      endcase
    end
    pc_d[0] = 1'b0;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= CSF_PC_RESET;
    end else if (stack_err) begin
      pc_q <= CSF_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ----------------------------------------------------------------
  // fetch, flush and data strobes
  // ----------------------------------------------------------------
  logic flush_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      INSTR_WORD <= 16'h0000;
      flush_q <= 1'b0;
      FLUSH <= 1'b0;
    end else begin
      if (exec_now) begin
        INSTR_WORD <= (pc_jump || flush_q) ? 16'h0000 : PM_WORD;
        flush_q <= pc_jump;
      end
      FLUSH <= exec_now && pc_jump;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PM_ADDR <= CSF_PC_RESET;
      PM_REQ <= 1'b0;
      DM_RD <= 1'b0;
      DM_WR <= 1'b0;
      PHASE <= 4'h1;
    end else begin
      PM_ADDR <= pc_q;
      PM_REQ <= (phase_q == CSF_Q3);
      DM_RD <= (phase_q == CSF_Q2);
      DM_WR <= (phase_q == CSF_Q4);
      PHASE <= phase_q;
    end
  end

  // ----------------------------------------------------------------
  // table read
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TBL_LATCH <= 8'h00;
    end else if (TBL_REQ) begin
      TBL_LATCH <= PM_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // apb read data
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  logic rd_err;
  always_comb begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    unique case (PADDR)
      CSF_ADDR_SPREG: rd_d = {24'h000000, full_q, unf_q, 1'b0, sp_q};
      CSF_ADDR_CTRL: rd_d = {31'h00000000, rsten_q};
      CSF_ADDR_TOS: rd_d = {11'h000, tos};
      CSF_ADDR_PC: rd_d = {11'h000, pc_q};
      CSF_ADDR_INSTR: rd_d = {16'h0000, INSTR_WORD};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && rd_err;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rd_d;
      end
    end
  end

endmodule : csf_core
`default_nettype wire

// [sim/csf_pm_model.sv]
`timescale 1ns/1ns
`default_nettype none
module csf_pm_model (
  // fetch
  input wire logic [20:0] pm_addr,
  input wire logic pm_req,
  output logic [15:0] pm_word,
  // table
  input wire logic [20:0] tbl_ptr,
  output logic [7:0] pm_byte
);
  logic [15:0] fw;
  logic [15:0] tw;
  // word address of an even byte address
  assign fw = pm_addr[16:1] ^ 16'h5a3c;
  assign pm_word = pm_req ? fw : ~fw;
  assign tw = tbl_ptr[16:1] ^ 16'h5a3c;
  assign pm_byte = tbl_ptr[0] ? tw[15:8] : tw[7:0];
endmodule : csf_pm_model
`default_nettype wire

// [sim/csf_core_props.sv]
`timescale 1ns/1ns
`default_nettype none
module csf_core_props #(
  parameter int DEPTH = csf_pkg::CSF_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pipeline
  input wire logic [20:0] PM_ADDR,
  input wire logic [15:0] INSTR_WORD,
  input wire logic FLUSH,
  input wire logic [3:0] PHASE,
  input wire logic DM_RD,
  input wire logic DM_WR,
  input wire logic CTX_LOAD,
  input wire logic DEV_RESET
);
  import csf_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // ---
  // sequences
  // ---
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_rest;
    PHASE == CSF_Q2 ##1 PHASE == CSF_Q3 ##1 PHASE == CSF_Q4;
  endsequence
  // ---
  // checks
  // ---
  a_apb_zero_wait: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_pc_even: assert property (!PM_ADDR[0])
    else $error("odd fetch address");
  a_phase_cycle: assert property (PHASE == CSF_Q1 && $past(PHASE) == CSF_Q4 |=> s_rest)
    else $error("phase order broken");
  a_phase_wrap: assert property (PHASE == CSF_Q4 |=> PHASE == CSF_Q1)
    else $error("phase wrap broken");
  a_rd_in_q2: assert property (DM_RD |-> PHASE == CSF_Q2)
    else $error("operand read off phase");
  a_wr_in_q4: assert property (DM_WR |-> PHASE == CSF_Q4)
    else $error("write off phase");
  a_flush_nop: assert property (FLUSH |-> INSTR_WORD == 16'h0000)
    else $error("flushed word kept");
  a_devrst_pulse: assert property (DEV_RESET |=> !DEV_RESET [*4])
    else $error("device reset too long");
  a_load_pulse: assert property (CTX_LOAD |=> !CTX_LOAD)
    else $error("restore too long");
endmodule : csf_core_props
bind csf_core csf_core_props #(.DEPTH(DEPTH)) u_props (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PM_ADDR(PM_ADDR),
  .INSTR_WORD(INSTR_WORD), .FLUSH(FLUSH), .PHASE(PHASE), .DM_RD(DM_RD), .DM_WR(DM_WR),
  .CTX_LOAD(CTX_LOAD), .DEV_RESET(DEV_RESET));
`default_nettype wire

// [sim/csf_core_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module csf_core_tb_top;
  import csf_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, tbl = 0;
  logic rdy, err, ld, fl, dr, req, eseen;
  logic [7:0] pa = 0, byt, lat;
  logic [31:0] pw = 0, pr, r;
  logic [20:0] pma, tp = 0;
  logic [15:0] pmw, ir;
  logic [3:0] ph;
  csf_cmd_t cmd = '0;
  csf_ctx_t ctx = '0, cr;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, nld = 0, nfl = 0, ndr = 0;
  csf_core dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pw), .PRDATA(pr), .PREADY(rdy), .PSLVERR(err), .PM_ADDR(pma),
    .PM_REQ(req), .PM_WORD(pmw), .PM_BYTE(byt), .TBL_REQ(tbl), .TBL_PTR(tp),
    .TBL_LATCH(lat), .CMD(cmd), .CTX(ctx), .CTX_RESTORE(cr), .CTX_LOAD(ld), .INSTR_WORD(ir),
    .FLUSH(fl), .PHASE(ph), .DM_RD(), .DM_WR(), .DEV_RESET(dr));
  csf_pm_model pm (.pm_addr(pma), .pm_req(req), .pm_word(pmw), .tbl_ptr(tp),
    .pm_byte(byt));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    nld += ld;
    nfl += fl;
    ndr += dr;
    if (cyc > 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    r = pr;
    eseen = err;
    psel <= 0;
    pen <= 0;
    if (n >= 20)
      chk(0, 1);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(r, e);
  endtask : rd
  task automatic op(input csf_op_t o, input logic f, input logic [19:0] t);
    @(posedge clk);
    cmd <= '{o, f, t, t[10:0], t[7:0]};
    repeat (4) @(posedge clk);
    cmd <= '0;
  endtask : op
  task automatic pc_in(input logic [20:0] lo);
    apb(0, CSF_ADDR_PC, 0);
    chk(r[31:21] == 0 && r[20:0] >= lo && r[20:0] < lo + 32 && !r[0], 1);
  endtask : pc_in
  task automatic sh(input csf_op_t o1, input csf_op_t o2, input logic f,
    input logic [19:0] v);
    int k;
    k = nld;
    ctx <= v;
    op(o1, f, 20'h00200);
    ctx <= 20'h0f0f0;
    op(o2, 1, 0);
    repeat (2) @(posedge clk);
    chk({12'h0, cr}, {12'h0, v});
    chk(nld - k, 1);
  endtask : sh
  task automatic t_stack;
    rd(CSF_ADDR_SPREG, 0);
    rd(CSF_ADDR_CTRL, 1);
    rd(CSF_ADDR_SHADOW, 0);
    chk(eseen, 1);
    apb(1, CSF_ADDR_CTRL, 0);
    for (int i = 0; i < 31; i++)
      op(CSF_OP_CALL, 0, 20'h00100);
    rd(CSF_ADDR_SPREG, 32'h9f);
    apb(1, CSF_ADDR_TOS, 32'h12344);
    op(CSF_OP_CALL, 0, 20'h00100);
    rd(CSF_ADDR_SPREG, 32'h9f);
    rd(CSF_ADDR_TOS, 32'h12344);
    apb(1, CSF_ADDR_SPREG, 32'ha1);
    rd(CSF_ADDR_SPREG, 32'h81);
    apb(1, CSF_ADDR_TOS, 32'h01234);
    op(CSF_OP_RET, 0, 0);
    rd(CSF_ADDR_SPREG, 32'h80);
    pc_in(21'h01234);
    op(CSF_OP_RET, 0, 0);
    rd(CSF_ADDR_SPREG, 32'hc0);
    rd(CSF_ADDR_TOS, 0);
    pc_in(0);
    chk(ndr, 0);
    apb(1, CSF_ADDR_SPREG, 0);
    rd(CSF_ADDR_SPREG, 0);
    apb(1, CSF_ADDR_CTRL, 1);
    op(CSF_OP_RET, 0, 0);
    repeat (2) @(posedge clk);
    chk(ndr, 1);
    rd(CSF_ADDR_SPREG, 32'h40);
    $display("stack test done");
  endtask : t_stack
  task automatic t_flow;
    int kf;
    ctx <= 20'h11111;
    op(CSF_OP_INT, 0, 20'h00100);
    sh(CSF_OP_INT, CSF_OP_RETINT, 0, 20'h5a3c1);
    sh(CSF_OP_CALL, CSF_OP_RET, 1, 20'h2b4d6);
    kf = nfl;
    op(CSF_OP_GOTO, 0, 20'h00400);
    repeat (2) @(posedge clk);
    chk(nfl - kf, 1);
    pc_in(21'h00800);
    op(CSF_OP_BRANCH, 0, 20'h00010);
    pc_in(21'h00820);
    op(CSF_OP_PCADD, 0, 20'h00004);
    apb(0, CSF_ADDR_PC, 0);
    chk(r[0], 0);
    tp <= 21'h00103;
    tbl <= 1;
    @(posedge clk);
    tbl <= 0;
    @(posedge clk);
    chk(lat, 8'h5a);
    $display("flow test done");
  endtask : t_flow
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    repeat (3) @(posedge clk);
    t_stack();
    t_flow();
    give_verdict();
  end
endmodule : csf_core_tb_top
`default_nettype wire
